// [rtmr_pkg.sv]
/*
 * Shared constants and types of the reloadable 16-bit timer: register
 * offsets, control field positions, reset values and the mode encoding.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses of 8 bits.
 */
package rtmr_pkg;

	// bus geometry and datapath widths
	localparam int RTMR_ADDR_W = 8;
	localparam int RTMR_DATA_W = 32;
	localparam int RTMR_CNT_W  = 16;
	localparam int RTMR_PRE_W  = 7;
	localparam int RTMR_IRQ_W  = 2;

	// register byte offsets
	localparam logic [7:0] RTMR_OFF_CTRL     = 8'h00;
	localparam logic [7:0] RTMR_OFF_COUNT    = 8'h04;
	localparam logic [7:0] RTMR_OFF_RELOAD   = 8'h08;
	localparam logic [7:0] RTMR_OFF_IRQ_STAT = 8'h0c;
	localparam logic [7:0] RTMR_OFF_IRQ_CLR  = 8'h10;
	localparam logic [7:0] RTMR_OFF_IRQ_EN   = 8'h14;

	// control register fields
	localparam int RTMR_CTRL_EN       = 0;
	localparam int RTMR_CTRL_MODE_LSB = 1;
	localparam int RTMR_CTRL_MODE_W   = 2;
	localparam int RTMR_CTRL_PRE_LSB  = 3;
	localparam int RTMR_CTRL_PRE_W    = 3;
	localparam int RTMR_CTRL_POL      = 6;
	localparam int RTMR_CTRL_OUTEN    = 7;

	// interrupt status bit positions
	localparam int RTMR_IRQ_RELOAD = 0;
	localparam int RTMR_IRQ_WRAP   = 1;

	// reset, restart and maximum count values
	localparam logic [7:0]  RTMR_CTRL_RST      = 8'h00;
	localparam logic [15:0] RTMR_COUNT_RST     = 16'h0000;
	localparam logic [15:0] RTMR_RELOAD_RST    = 16'h0000;
	localparam logic [15:0] RTMR_COUNT_RESTART = 16'h0001;
	localparam logic [15:0] RTMR_COUNT_MAX     = 16'hffff;
	localparam logic [1:0]  RTMR_IRQ_EN_RST    = 2'h0;

	// bus response codes
	localparam logic [1:0] RTMR_RESP_OKAY   = 2'h0;
	localparam logic [1:0] RTMR_RESP_SLVERR = 2'h2;

	// operating modes
	typedef enum logic [1:0] {
		rtmr_one_shot,
		rtmr_free_run_reload_mode,
		rtmr_counter,
		rtmr_mode_spare
	} rtmr_mode_e;

endpackage

// [rtmr_edge.sv]
/*
 * Input edge detector for the timer input pin: a two-stage synchroniser
 * followed by a one-cycle-delayed copy, giving rising and falling strobes.
 * Assumes the pin toggles no faster than a quarter of sys_clk.
 */
module rtmr_edge
	import rtmr_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic din,
	output logic      rise,
	output logic      fall
);

	logic sync1;
	logic sync2;
	logic prev;

	// synchroniser and previous sample
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			prev  <= 1'b0;
		end else begin
			sync1 <= din;
			sync2 <= sync1;
			prev  <= sync2;
		end
	end

	// compare consecutive synchronised samples
	assign rise = sync2 & ~prev; // [RQ19]
	assign fall = ~sync2 & prev; // [RQ19]

endmodule

// [rtmr_top.sv]
/*
 * Reloadable 16-bit up-counting timer with prescaler, three modes, timer
 * output pin, sticky interrupts and an AXI4-Lite register slave.
 * Assumes one clock, an AXI4-Lite master that keeps the handshake rules,
 * and a timer input pin that is slow against sys_clk.
 */
// The AXI4-Lite slave port and the address map were left to the implementer.

// Behaviour
// [RQ1] Count is a 16-bit up-counter wrapping from all ones to zero.
// [RQ2] Prescaler divides sys_clk by a power of two from 1 to 128.
// [RQ3] Reload zero with prescale 128 is longest; reload one, prescale 1 shortest.
// [RQ4] One-shot reload: interrupt, count to one, enable cleared, stop.
// [RQ5] One-shot reload inverts the output pin for exactly one cycle.
// [RQ6] Software sets polarity to start level, starts, then writes the opposite.
// [RQ7] Free-run reload: interrupt, count to one, keep counting.
// [RQ8] Free-run and counter modes toggle and hold the output at each reload.
// [RQ9] Written start count holds for the first pass only; later passes start at one.
// [RQ10] One-shot and free-run modes count prescaled clocks, never the input pin.
// [RQ11] Counter mode counts input edges; polarity set means rising, clear falling.
// [RQ12] Counter mode bypasses the prescaler, one count per qualifying edge.
// [RQ13] Counter mode reload: interrupt, count to one, keep counting edges.
// [RQ14] The input source toggles no faster than a quarter of sys_clk.
// [RQ15] Polarity bit gives the output level while the timer is idle.
// [RQ16] Software disables, configures, loads count and reload, then enables.
// [RQ17] Current count is readable at any time.
// [RQ18] Prescaler divider is cleared while the timer is disabled.
// [RQ19] Edges come from synchronised consecutive samples; one event pulse per reload.
module rtmr_top
	import rtmr_pkg::*;
(
	input  wire logic                   sys_clk,
	input  wire logic                   rst,
	input  wire logic [RTMR_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]             s_axi_awprot,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [RTMR_DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [RTMR_ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]             s_axi_arprot,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [RTMR_DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	input  wire logic                   timer_in,
	output logic                        timer_out,
	output logic                        timer_out_oe,
	output logic                        reload_pulse,
	output logic                        irq
);

	// register state
	logic [7:0]            ctrl;
	logic [RTMR_CNT_W-1:0] count;
	logic [RTMR_CNT_W-1:0] reload;
	logic [RTMR_IRQ_W-1:0] irq_stat;
	logic [RTMR_IRQ_W-1:0] irq_en;

	// decoded control fields
	logic                  run;
	rtmr_mode_e            mode;
	logic [2:0]            pre_sel;
	logic                  output_polarity_select;

	// counting datapath
	logic [RTMR_PRE_W-1:0] pre_cnt;
	logic [RTMR_PRE_W-1:0] pre_top;
	logic                  pre_tick;
	logic                  in_rise;
	logic                  in_fall;
	logic                  edge_hit;
	logic                  adv;
	logic                  reload_hit;
	logic                  wrap_hit;
	logic [RTMR_IRQ_W-1:0] irq_event;

	// write channel state and read handshake
	logic                   aw_full;
	logic [RTMR_ADDR_W-1:0] aw_addr_q;
	logic                   w_full;
	logic [RTMR_DATA_W-1:0] w_data_q;
	logic [3:0]             w_strb_q;
	logic                   aw_hs;
	logic                   w_hs;
	logic                   wr_go;
	logic [RTMR_ADDR_W-1:0] wr_addr;
	logic [RTMR_DATA_W-1:0] wr_data;
	logic [3:0]             wr_strb;
	logic                   ctrl_wr;
	logic                   count_wr;
	logic                   reload_wr;
	logic                   clr_wr;
	logic                   en_wr;
	logic                   wr_mapped;
	logic [RTMR_IRQ_W-1:0]  irq_clr;
	logic                   ar_hs;

	// byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(
		input logic [15:0] old,
		input logic [31:0] data,
		input logic [3:0]  strb
	);
		logic [15:0] res;
		res[7:0]  = strb[0] ? data[7:0] : old[7:0];
		res[15:8] = strb[1] ? data[15:8] : old[15:8];
		return res;
	endfunction

	// address is one of the mapped offsets
	function automatic logic is_mapped(input logic [7:0] addr);
		return (addr == RTMR_OFF_CTRL) || (addr == RTMR_OFF_COUNT) ||
			(addr == RTMR_OFF_RELOAD) || (addr == RTMR_OFF_IRQ_STAT) ||
			(addr == RTMR_OFF_IRQ_CLR) || (addr == RTMR_OFF_IRQ_EN);
	endfunction

	// control field decode
	assign run                    = ctrl[RTMR_CTRL_EN];
	assign mode                   = rtmr_mode_e'(ctrl[RTMR_CTRL_MODE_LSB +: RTMR_CTRL_MODE_W]);
	assign pre_sel                = ctrl[RTMR_CTRL_PRE_LSB +: RTMR_CTRL_PRE_W];
	assign output_polarity_select = ctrl[RTMR_CTRL_POL];

	// prescaler terminal value, divide by 2 to the power pre_sel
	assign pre_top  = RTMR_PRE_W'((8'h01 << pre_sel) - 8'h01); // [RQ2]
	assign pre_tick = (pre_cnt == pre_top);

	// prescaler divider, held at zero while idle or in counter mode
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pre_cnt <= '0;
		end else if (!run || mode == rtmr_counter) begin
			pre_cnt <= '0; // [RQ18] [RQ12]
		end else if (pre_tick) begin
			pre_cnt <= '0; // [RQ2]
		end else begin
			pre_cnt <= pre_cnt + 7'h01;
		end
	end

	// timer input edge detection
	rtmr_edge u_edge (
		.sys_clk (sys_clk),
		.rst     (rst),
		.din     (timer_in),
		.rise    (in_rise),
		.fall    (in_fall)
	);

	// polarity picks the counted edge
	assign edge_hit = output_polarity_select ? in_rise : in_fall; // [RQ11]

	// count source per mode
	always_comb begin
		adv = 1'b0;
		unique case (mode)
			rtmr_one_shot: begin
				adv = run & pre_tick; // [RQ10]
			end
			rtmr_free_run_reload_mode: begin
				adv = run & pre_tick; // [RQ10]
			end
			rtmr_counter: begin
				adv = run & edge_hit; // [RQ11] [RQ12]
			end
			rtmr_mode_spare: begin
				adv = 1'b0;
			end
		endcase
	end

	// reload match on the advancing step; reload zero takes a full wrap
	assign reload_hit = adv && (count == reload); // [RQ3]
	assign wrap_hit   = adv && !reload_hit && (count == RTMR_COUNT_MAX);

	// counter register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			count <= RTMR_COUNT_RST;
		end else if (count_wr) begin
			count <= merge16(count, wr_data, wr_strb); // [RQ9]
		end else if (reload_hit) begin
			count <= RTMR_COUNT_RESTART; // [RQ4] [RQ7] [RQ9] [RQ13]
		end else if (adv) begin
			count <= count + 16'h0001; // [RQ1]
		end
	end

	// reload register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reload <= RTMR_RELOAD_RST;
		end else if (reload_wr) begin
			reload <= merge16(reload, wr_data, wr_strb);
		end
	end

	// control register; one-shot drops its own enable at reload
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl <= RTMR_CTRL_RST;
		end else if (ctrl_wr) begin
			ctrl <= wr_data[7:0];
		end else if (reload_hit && mode == rtmr_one_shot) begin
			ctrl[RTMR_CTRL_EN] <= 1'b0; // [RQ4]
		end
	end

	// timer output level
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			timer_out <= 1'b0;
		end else if (mode == rtmr_one_shot) begin
			timer_out <= output_polarity_select ^ reload_hit; // [RQ5] [RQ6]
		end else if (!run) begin
			timer_out <= output_polarity_select; // [RQ15]
		end else if (reload_hit) begin
			timer_out <= ~timer_out; // [RQ8]
		end
	end

	// output drive follows the output function enable
	assign timer_out_oe = ctrl[RTMR_CTRL_OUTEN];

	// one-cycle event strobe per reload
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reload_pulse <= 1'b0;
		end else begin
			reload_pulse <= reload_hit; // [RQ19]
		end
	end

	// interrupt events
	always_comb begin
		irq_event                  = '0;
		irq_event[RTMR_IRQ_RELOAD] = reload_hit; // [RQ4] [RQ7] [RQ13]
		irq_event[RTMR_IRQ_WRAP]   = wrap_hit;
	end

	// sticky status, a new event wins over a clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq_stat <= '0;
		end else begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_event;
		end
	end

	// interrupt enable register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq_en <= RTMR_IRQ_EN_RST;
		end else if (en_wr) begin
			irq_en <= wr_data[RTMR_IRQ_W-1:0];
		end
	end

	// level interrupt
	assign irq = |(irq_stat & irq_en);

	// write channel handshakes, address and data in either order
	assign s_axi_awready = !aw_full && !s_axi_bvalid;
	assign s_axi_wready  = !w_full && !s_axi_bvalid;
	assign aw_hs         = s_axi_awvalid && s_axi_awready;
	assign w_hs          = s_axi_wvalid && s_axi_wready;
	assign wr_go         = (aw_full || aw_hs) && (w_full || w_hs) && !s_axi_bvalid;
	assign wr_addr       = aw_full ? aw_addr_q : s_axi_awaddr;
	assign wr_data       = w_full ? w_data_q : s_axi_wdata;
	assign wr_strb       = w_full ? w_strb_q : s_axi_wstrb;

	// write address decode
	assign ctrl_wr   = wr_go && (wr_addr == RTMR_OFF_CTRL) && wr_strb[0];
	assign count_wr  = wr_go && (wr_addr == RTMR_OFF_COUNT) && (|wr_strb[1:0]);
	assign reload_wr = wr_go && (wr_addr == RTMR_OFF_RELOAD) && (|wr_strb[1:0]);
	assign clr_wr    = wr_go && (wr_addr == RTMR_OFF_IRQ_CLR) && wr_strb[0];
	assign en_wr     = wr_go && (wr_addr == RTMR_OFF_IRQ_EN) && wr_strb[0];
	assign wr_mapped = is_mapped(wr_addr);
	assign irq_clr   = clr_wr ? wr_data[RTMR_IRQ_W-1:0] : '0;

	// held write address
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			aw_full   <= 1'b0;
			aw_addr_q <= '0;
		end else if (wr_go) begin
			aw_full <= 1'b0;
		end else if (aw_hs) begin
			aw_full   <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end
	end

	// held write data
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			w_full   <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= 4'h0;
		end else if (wr_go) begin
			w_full <= 1'b0;
		end else if (w_hs) begin
			w_full   <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end
	end

	// write response
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RTMR_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_mapped ? RTMR_RESP_OKAY : RTMR_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read channel, one read in flight
	assign s_axi_arready = !s_axi_rvalid;
	assign ar_hs         = s_axi_arvalid && s_axi_arready;

	// read data, count is the live value
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RTMR_RESP_OKAY;
		end else if (ar_hs) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= is_mapped(s_axi_araddr) ? RTMR_RESP_OKAY : RTMR_RESP_SLVERR;
			unique case (s_axi_araddr)
				RTMR_OFF_CTRL: begin
					s_axi_rdata <= {24'h000000, ctrl};
				end
				RTMR_OFF_COUNT: begin
					s_axi_rdata <= {16'h0000, count}; // [RQ17]
				end
				RTMR_OFF_RELOAD: begin
					s_axi_rdata <= {16'h0000, reload};
				end
				RTMR_OFF_IRQ_STAT: begin
					s_axi_rdata <= {30'h00000000, irq_stat};
				end
				RTMR_OFF_IRQ_EN: begin
					s_axi_rdata <= {30'h00000000, irq_en};
				end
				default: begin
					s_axi_rdata <= '0;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// [rtmr_top_sva.sv]
/*
 * port checker for rtmr_top: bus handshakes and output toggling.
 * assumes a single sys_clk domain with rst active high.
 */
module rtmr_top_sva
	import rtmr_pkg::*;
(
	input wire logic                   sys_clk,
	input wire logic                   rst,
	input wire logic                   s_axi_awvalid,
	input wire logic                   s_axi_awready,
	input wire logic                   s_axi_wvalid,
	input wire logic                   s_axi_wready,
	input wire logic [1:0]             s_axi_bresp,
	input wire logic                   s_axi_bvalid,
	input wire logic                   s_axi_bready,
	input wire logic                   s_axi_arvalid,
	input wire logic                   s_axi_arready,
	input wire logic [RTMR_DATA_W-1:0] s_axi_rdata,
	input wire logic                   s_axi_rvalid,
	input wire logic                   s_axi_rready,
	input wire logic                   timer_out,
	input wire logic                   timer_out_oe,
	input wire logic                   reload_pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	// bus steps
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_b_wait;
		s_axi_bvalid && !s_axi_bready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence

	a_write_answer:
		assert property (s_wr_take |=> s_axi_bvalid) else $error("no write response");
	a_b_holds:
		assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_b_release:
		assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response kept");
	a_w_refused:
		assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	a_ready_back:
		assert property ($fell(s_axi_bvalid) |-> s_axi_awready && s_axi_wready)
		else $error("write ready not restored");
	a_read_answer:
		assert property (s_rd_take |=> s_axi_rvalid) else $error("no read response");
	a_r_holds:
		assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_r_release:
		assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read response kept");
	a_r_refused:
		assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
	a_out_flips:
		assert property ($rose(reload_pulse) && timer_out_oe |-> timer_out != $past(timer_out))
		else $error("output not inverted at reload");
endmodule

bind rtmr_top rtmr_top_sva rtmr_top_sva_i (.sys_clk, .rst, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .timer_out, .timer_out_oe,
	.reload_pulse);

// [rtmr_pin_model.sv]
/*
 * external source on the timer input pin.
 * assumes sys_clk from the bench; levels change just after a rising edge.
 */
module rtmr_pin_model (
	input  wire logic sys_clk,
	output logic      timer_in
);
	timeunit 1ns;
	timeprecision 1ns;
	initial timer_in = 1'h0;

	// one level change, then held four clocks so no edge is missed
	task automatic drive(input logic v);
		@(posedge sys_clk);
		timer_in <= v;
		repeat (4) @(posedge sys_clk);
	endtask
endmodule

// [rtmr_top_test.sv]
/*
 * bench for rtmr_top: bus tasks, timer scenarios and the verdict.
 * assumes rtmr_pin_model drives the timer input pin.
 */
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fail_count++; \
	$display("Error %s expected %h seen %h", n, e, s); end end
module rtmr_top_test
	import rtmr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sys_clk = 1'h0;
	logic        rst = 1'h1;
	logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
	logic [1:0]  s_axi_bresp, s_axi_rresp, brsp, rrsp;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        timer_in, timer_out, timer_out_oe, reload_pulse, irq;
	logic [15:0] cexp [8] = '{16'h2, 16'h2, 16'h1, 16'h1, 16'hffff, 16'h0, 16'h0, 16'h1};
	int          fail_count = 0, checked = 0, p, f;

	rtmr_top rtmr_top_i (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .timer_in, .timer_out, .timer_out_oe, .reload_pulse, .irq);
	rtmr_pin_model rtmr_pin_model_i (.sys_clk, .timer_in);

	always #5 sys_clk = ~sys_clk;

	// bus write: both halves offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		fork
			begin do @(posedge sys_clk); while (!s_axi_awready); s_axi_awvalid <= 1'h0; end
			begin do @(posedge sys_clk); while (!s_axi_wready); s_axi_wvalid <= 1'h0; end
		join
		do @(posedge sys_clk); while (!s_axi_bvalid);
		brsp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask

	// bus read
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge sys_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge sys_clk); while (!s_axi_rvalid);
		rdat = s_axi_rdata;
		rrsp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask

	// cycles to the first reload pulse, then to the next one; 3000 if none
	task automatic gap(output int n, output int f);
		f = 0;
		while (!reload_pulse && f < 3000) begin @(posedge sys_clk); f++; end
		n = 0;
		do begin @(posedge sys_clk); n++; end while (!reload_pulse && n < 3000);
	endtask

	task automatic done(input string s);
		$display("test %s done", s);
	endtask

	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// watchdog against a hung handshake
	initial begin
		#400000;
		fail_count++;
		report_and_stop();
	end

	initial begin
		repeat (10) @(posedge sys_clk);
		rst <= 1'h0;
		// reset values, read-only status and an unmapped place
		for (int i = 0; i < 6; i++) begin
			rd(8'(4 * i));
			`CHK("reset value", 32'h0, rdat);
		end
		wr(RTMR_OFF_IRQ_STAT, 32'h3);
		rd(RTMR_OFF_IRQ_STAT);
		`CHK("status read-only", 32'h0, rdat);
		wr(8'h18, 32'h1);
		`CHK("write unmapped", RTMR_RESP_SLVERR, brsp);
		rd(8'h18);
		`CHK("read unmapped", RTMR_RESP_SLVERR, rrsp);
		wr(RTMR_OFF_CTRL, 32'hc0);
		@(posedge sys_clk);
		`CHK("idle level", 2'h3, {timer_out_oe, timer_out});
		done("registers");
		// free-run: short first pass, then full periods from one
		wr(RTMR_OFF_IRQ_EN, 32'h1);
		wr(RTMR_OFF_COUNT, 32'h5);
		wr(RTMR_OFF_RELOAD, 32'h6);
		wr(RTMR_OFF_CTRL, 32'h83);
		gap(p, f);
		`CHK("first pass", 2, f);
		`CHK("reload period", 6, p);
		`CHK("irq raised", 1'h1, irq);
		wr(RTMR_OFF_CTRL, 32'h80);
		wr(RTMR_OFF_IRQ_EN, 32'h0);
		`CHK("irq masked", 1'h0, irq);
		wr(RTMR_OFF_IRQ_EN, 32'h1);
		wr(RTMR_OFF_IRQ_CLR, 32'h1);
		`CHK("irq cleared", 1'h0, irq);
		done("free run");
		// every prescale code, then the shortest time-out
		for (int n = 0; n < 8; n++) begin
			wr(RTMR_OFF_CTRL, 32'h0);
			wr(RTMR_OFF_COUNT, 32'h1);
			wr(RTMR_OFF_RELOAD, 32'h2);
			wr(RTMR_OFF_CTRL, 32'(3 + 8 * n));
			gap(p, f);
			`CHK("prescaled period", 2 << n, p);
			`CHK("first period", 2 << n, f);
		end
		wr(RTMR_OFF_RELOAD, 32'h1);
		wr(RTMR_OFF_CTRL, 32'h3);
		gap(p, f);
		`CHK("shortest period", 1, p);
		done("prescaler");
		// one-shot: start low, flip polarity once running, single reload, then stopped
		wr(RTMR_OFF_CTRL, 32'h80);
		wr(RTMR_OFF_RELOAD, 32'h8);
		wr(RTMR_OFF_CTRL, 32'h81);
		wr(RTMR_OFF_CTRL, 32'hc1);
		gap(p, f);
		`CHK("no second shot", 3000, p);
		rd(RTMR_OFF_CTRL);
		`CHK("enable cleared", 32'hc0, rdat);
		rd(RTMR_OFF_COUNT);
		`CHK("count after shot", 32'h1, rdat);
		`CHK("level kept", 1'h1, timer_out);
		done("one shot");
		// counter mode: rising at prescale 128, then falling with a wrap
		for (int m = 0; m < 2; m++) begin
			wr(RTMR_OFF_CTRL, 32'h0);
			wr(RTMR_OFF_COUNT, m ? 32'hffff : 32'h1);
			wr(RTMR_OFF_RELOAD, m ? 32'h0 : 32'h2);
			wr(RTMR_OFF_CTRL, m ? 32'h05 : 32'h7d);
			for (int k = 0; k < 4; k++) begin
				rtmr_pin_model_i.drive(k % 2 == 0);
				rd(RTMR_OFF_COUNT);
				`CHK("edge count", {16'h0, cexp[4 * m + k]}, rdat);
			end
		end
		rd(RTMR_OFF_IRQ_STAT);
		`CHK("reload and wrap flagged", 32'h3, rdat);
		done("counter");
		// pin toggles ignored by one-shot at prescale 128 and by the spare mode
		for (int m = 0; m < 2; m++) begin
			wr(RTMR_OFF_CTRL, 32'h0);
			wr(RTMR_OFF_CTRL, m ? 32'h07 : 32'h39);
			rtmr_pin_model_i.drive(1'h1);
			rtmr_pin_model_i.drive(1'h0);
			rd(RTMR_OFF_COUNT);
			`CHK("pin ignored", 32'h1, rdat);
		end
		done("pin ignored");
		report_and_stop();
	end
endmodule
